// ==== pkg/plmc_consts.svh ====
// Constants for the proximity and ambient light configuration block.
// Assumes a 50 ns system clock and byte-wide register access.
`ifndef PLMC_CONSTS_SVH
`define PLMC_CONSTS_SVH

// ==========================================================
// Register offsets
`define PLMC_ADDR_MODE      8'h81
`define PLMC_ADDR_DRIVE     8'h82
`define PLMC_ADDR_PULSES    8'h83
`define PLMC_ADDR_PROXRATE  8'h84
`define PLMC_ADDR_LIGHTRATE 8'h85
`define PLMC_ADDR_IDENT     8'h86

// ==========================================================
// Reset values and field positions
`define PLMC_RST_MODE       8'h0c
`define PLMC_RST_DRIVE      8'h6b
`define PLMC_RST_PULSES     8'h7f
`define PLMC_RST_PROXRATE   8'h03
`define PLMC_RST_LIGHTRATE  8'h82
`define PLMC_MODE_BIT       1
`define PLMC_PULSE_MAX      8'hfe

// ==========================================================
// Timing: clock period, microsecond tick, emitter period in cycles
`define PLMC_CLK_NS         50
`define PLMC_TICK_NS        1000
`define PLMC_EMIT_CYC(k)    (1000000 / ((k) * `PLMC_CLK_NS))
`define PLMC_EMIT_KHZ_BASE  30
`define PLMC_EMIT_KHZ_STEP  10

// Proximity repeat intervals, microseconds
`define PLMC_PR_0  21'd12500
`define PLMC_PR_1  21'd50000
`define PLMC_PR_2  21'd70000
`define PLMC_PR_3  21'd100000
`define PLMC_PR_4  21'd200000
`define PLMC_PR_5  21'd500000
`define PLMC_PR_6  21'd1000000
`define PLMC_PR_7  21'd2000000
// Ambient light repeat intervals, microseconds
`define PLMC_LR_0  21'd100000
`define PLMC_LR_1  21'd200000
`define PLMC_LR_2  21'd500000
`define PLMC_LR_3  21'd1000000
`define PLMC_LR_X  21'd2000000
// Integration times, microseconds (292.8 and 18.3 rounded down to whole us)
`define PLMC_IT_0  21'd1200000
`define PLMC_IT_1  21'd600000
`define PLMC_IT_2  21'd300000
`define PLMC_IT_3  21'd150000
`define PLMC_IT_4  21'd75000
`define PLMC_IT_5  21'd4685
`define PLMC_IT_6  21'd292
`define PLMC_IT_7  21'd18

`endif

// ==== pkg/plmc_pkg.sv ====
// Types for the proximity and ambient light configuration block.
// Assumes plmc_consts.svh supplies all numeric constants.
package plmc_pkg;

	// ======================================================
	// Register access request from the serial interface
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} plmc_req_t;

	// ======================================================
	// Emitter burst states
	typedef enum logic [1:0] {
		PLMC_EM_IDLE,
		PLMC_EM_HIGH,
		PLMC_EM_LOW
	} plmc_emit_t;

endpackage

// ==== src/plmc_top.sv ====
// Configuration registers and measurement timing for the proximity and
// ambient light sensor. Assumes the serial interface core presents
// decoded byte reads and writes, synchronous to SYS_CLK.
`timescale 1ns/1ps
`include "plmc_consts.svh"

module plmc_top
	import plmc_pkg::*;
#(
	parameter int          TICK_CYCLES  = `PLMC_TICK_NS / `PLMC_CLK_NS,
	// Arbitrary identification value
	parameter logic [7:0]  PART_IDENT   = 8'h5a
)
(
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	input  wire plmc_req_t  REG_REQ,
	input  wire logic       LIGHT_ENABLE,
	output logic      [7:0] REG_RDATA,
	output logic            REG_RVALID,
	output logic            PROX_MEAS_START,
	output logic            PROX_BURST_DONE,
	output logic            LIGHT_MEAS_START,
	output logic            EMIT_PULSE,
	output logic      [6:0] EMIT_CURRENT_MA,
	output logic      [4:0] LIGHT_RES_BITS
);

	// ======================================================
	// Decode functions
	function automatic logic [20:0] prox_interval(input logic [2:0] c);
		unique case (c)
			3'h0: prox_interval = `PLMC_PR_0;
			3'h1: prox_interval = `PLMC_PR_1;
			3'h2: prox_interval = `PLMC_PR_2;
			3'h3: prox_interval = `PLMC_PR_3;
			3'h4: prox_interval = `PLMC_PR_4;
			3'h5: prox_interval = `PLMC_PR_5;
			3'h6: prox_interval = `PLMC_PR_6;
			3'h7: prox_interval = `PLMC_PR_7;
		endcase
	endfunction

	function automatic logic [20:0] light_interval(input logic [2:0] c);
		unique case (c)
			3'h0:    light_interval = `PLMC_LR_0;
			3'h1:    light_interval = `PLMC_LR_1;
			3'h2:    light_interval = `PLMC_LR_2;
			3'h3:    light_interval = `PLMC_LR_3;
			default: light_interval = `PLMC_LR_X;
		endcase
	endfunction

	function automatic logic [20:0] integ_time(input logic [2:0] c);
		unique case (c)
			3'h0: integ_time = `PLMC_IT_0;
			3'h1: integ_time = `PLMC_IT_1;
			3'h2: integ_time = `PLMC_IT_2;
			3'h3: integ_time = `PLMC_IT_3;
			3'h4: integ_time = `PLMC_IT_4;
			3'h5: integ_time = `PLMC_IT_5;
			3'h6: integ_time = `PLMC_IT_6;
			3'h7: integ_time = `PLMC_IT_7;
		endcase
	endfunction

	function automatic logic [9:0] emit_period(input logic [2:0] c);
		logic [7:0] khz;
		khz = 8'(`PLMC_EMIT_KHZ_BASE + `PLMC_EMIT_KHZ_STEP * int'(c));
		emit_period = 10'(1000000 / (int'(khz) * `PLMC_CLK_NS));
	endfunction

	// ======================================================
	// Configuration registers
	logic [7:0] mode_reg;
	logic [7:0] drive_reg;
	logic [7:0] pulses_reg;
	logic [7:0] prox_rate_reg;
	logic [7:0] light_rate_reg;
	logic       wr_mode;
	logic       wr_drive;
	logic       wr_pulses;
	logic       wr_prox;
	logic       wr_light;

	assign wr_mode   = REG_REQ.wr && REG_REQ.addr == `PLMC_ADDR_MODE;
	assign wr_drive  = REG_REQ.wr && REG_REQ.addr == `PLMC_ADDR_DRIVE;
	assign wr_pulses = REG_REQ.wr && REG_REQ.addr == `PLMC_ADDR_PULSES;
	assign wr_prox   = REG_REQ.wr && REG_REQ.addr == `PLMC_ADDR_PROXRATE;
	assign wr_light  = REG_REQ.wr && REG_REQ.addr == `PLMC_ADDR_LIGHTRATE;

	// Registers are written in any mode; ident has no write path
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			mode_reg       <= `PLMC_RST_MODE;
			drive_reg      <= `PLMC_RST_DRIVE;
			pulses_reg     <= `PLMC_RST_PULSES;
			prox_rate_reg  <= `PLMC_RST_PROXRATE;
			light_rate_reg <= `PLMC_RST_LIGHTRATE;
		end
		else
		begin
			if (wr_mode)   mode_reg       <= REG_REQ.wdata;
			if (wr_drive)  drive_reg      <= REG_REQ.wdata;
			if (wr_pulses) pulses_reg     <= REG_REQ.wdata;
			if (wr_prox)   prox_rate_reg  <= REG_REQ.wdata;
			if (wr_light)  light_rate_reg <= REG_REQ.wdata;
		end
	end

	// ======================================================
	// Read port, data one cycle after the request
	logic [7:0] rdata_next;

	always_comb
	begin
		unique case (REG_REQ.addr)
			`PLMC_ADDR_MODE:      rdata_next = mode_reg;
			`PLMC_ADDR_DRIVE:     rdata_next = drive_reg;
			`PLMC_ADDR_PULSES:    rdata_next = pulses_reg;
			`PLMC_ADDR_PROXRATE:  rdata_next = prox_rate_reg;
			`PLMC_ADDR_LIGHTRATE: rdata_next = light_rate_reg;
			`PLMC_ADDR_IDENT:     rdata_next = PART_IDENT;
			default:              rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			REG_RVALID <= REG_REQ.rd;
			if (REG_REQ.rd)
				REG_RDATA <= rdata_next;
		end
	end

	// ======================================================
	// Microsecond timebase
	logic [15:0] tick_cnt_reg;
	logic        tick;

	assign tick = tick_cnt_reg == 16'(TICK_CYCLES - 1);

	always_ff @(posedge SYS_CLK)
	begin
		if (RST || tick)
			tick_cnt_reg <= 16'h0000;
		else
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
	end

	// ======================================================
	// Proximity repeat timer
	logic        prox_active;
	logic [20:0] prox_target;
	logic [20:0] prox_cnt_reg;
	logic        prox_fire;

	assign prox_active = mode_reg[`PLMC_MODE_BIT];
	assign prox_target = prox_interval(prox_rate_reg[2:0]);
	assign prox_fire   = prox_active && tick
		&& prox_cnt_reg >= prox_target - 21'h000001;

	always_ff @(posedge SYS_CLK)
	begin
		if (RST || !prox_active || prox_fire)
			prox_cnt_reg <= 21'h000000;
		else if (tick)
			prox_cnt_reg <= prox_cnt_reg + 21'h000001;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			PROX_MEAS_START <= 1'b0;
		else
			PROX_MEAS_START <= prox_fire;
	end

	// ======================================================
	// Ambient light repeat timer
	logic        light_run;
	logic [20:0] light_integ;
	logic [20:0] light_rep;
	logic [20:0] light_eff;
	logic [20:0] light_cnt_reg;
	logic        light_fire;

	assign light_run   = LIGHT_ENABLE && prox_rate_reg[2:0] != 3'h0;
	assign light_integ = integ_time(light_rate_reg[7:5]);
	assign light_rep   = light_interval(light_rate_reg[2:0]);
	assign light_eff   = (light_rep > light_integ) ? light_rep
		: light_integ + 21'h000001;
	assign light_fire  = light_run && tick
		&& light_cnt_reg >= light_eff - 21'h000001;

	always_ff @(posedge SYS_CLK)
	begin
		if (RST || !light_run || light_fire)
			light_cnt_reg <= 21'h000000;
		else if (tick)
			light_cnt_reg <= light_cnt_reg + 21'h000001;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			LIGHT_MEAS_START <= 1'b0;
		else
			LIGHT_MEAS_START <= light_fire;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			LIGHT_RES_BITS <= 5'h10;
		else
			unique case (light_rate_reg[7:5])
				3'h0: LIGHT_RES_BITS <= 5'h14;
				3'h1: LIGHT_RES_BITS <= 5'h13;
				3'h2: LIGHT_RES_BITS <= 5'h12;
				3'h3: LIGHT_RES_BITS <= 5'h11;
				3'h4: LIGHT_RES_BITS <= 5'h10;
				3'h5: LIGHT_RES_BITS <= 5'h0c;
				3'h6: LIGHT_RES_BITS <= 5'h08;
				3'h7: LIGHT_RES_BITS <= 5'h04;
			endcase
	end

	// ======================================================
	// Emitter peak current
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			EMIT_CURRENT_MA <= 7'h32;
		else
			unique case (drive_reg[2:0])
				3'h0:    EMIT_CURRENT_MA <= 7'h05;
				3'h1:    EMIT_CURRENT_MA <= 7'h0a;
				3'h2:    EMIT_CURRENT_MA <= 7'h14;
				3'h3:    EMIT_CURRENT_MA <= 7'h32;
				default: EMIT_CURRENT_MA <= 7'h64;
			endcase
	end

	// ======================================================
	// Emitter burst: square wave at the selected frequency
	plmc_emit_t  em_state_reg;
	logic [9:0]  em_cyc_reg;
	logic [7:0]  pulses_left_reg;
	logic [9:0]  em_period;
	logic [9:0]  em_half;
	logic [7:0]  burst_len;

	assign em_period = emit_period(drive_reg[7:5]);
	assign em_half   = em_period >> 1;
	assign burst_len = (pulses_reg > `PLMC_PULSE_MAX)
		? `PLMC_PULSE_MAX : pulses_reg;

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			em_state_reg    <= PLMC_EM_IDLE;
			em_cyc_reg      <= 10'h000;
			pulses_left_reg <= 8'h00;
		end
		else
		begin
			em_cyc_reg <= em_cyc_reg + 10'h001;
			unique case (em_state_reg)
				PLMC_EM_IDLE:
					if (prox_fire && burst_len != 8'h00)
					begin
						em_state_reg    <= PLMC_EM_HIGH;
						em_cyc_reg      <= 10'h000;
						pulses_left_reg <= burst_len;
					end
				PLMC_EM_HIGH:
					if (em_cyc_reg >= em_half - 10'h001)
						em_state_reg <= PLMC_EM_LOW;
				PLMC_EM_LOW:
					if (em_cyc_reg >= em_period - 10'h001)
					begin
						em_cyc_reg      <= 10'h000;
						pulses_left_reg <= pulses_left_reg - 8'h01;
						em_state_reg    <= (pulses_left_reg == 8'h01)
							? PLMC_EM_IDLE : PLMC_EM_HIGH;
					end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			EMIT_PULSE      <= 1'b0;
			PROX_BURST_DONE <= 1'b0;
		end
		else
		begin
			EMIT_PULSE      <= em_state_reg == PLMC_EM_HIGH;
			PROX_BURST_DONE <= (em_state_reg == PLMC_EM_LOW
				&& em_cyc_reg >= em_period - 10'h001
				&& pulses_left_reg == 8'h01)
				|| (em_state_reg == PLMC_EM_IDLE && prox_fire
				&& burst_len == 8'h00);
		end
	end

	// ======================================================
	// Checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	property p_prox_idle;
		!prox_active |=> !PROX_MEAS_START;
	endproperty
	a_prox_idle: assert property (p_prox_idle)
		else $error("proximity start while in standby");

	property p_light_suppress;
		prox_rate_reg[2:0] == 3'h0 |=> !LIGHT_MEAS_START;
	endproperty
	a_light_suppress: assert property (p_light_suppress)
		else $error("light start with fastest proximity rate");

	property p_pulse_cap;
		pulses_left_reg <= 8'hfe;
	endproperty
	a_pulse_cap: assert property (p_pulse_cap)
		else $error("burst longer than 254 pulses");

	property p_ident_read;
		REG_REQ.rd && REG_REQ.addr == `PLMC_ADDR_IDENT
			|=> REG_RVALID && REG_RDATA == PART_IDENT;
	endproperty
	a_ident_read: assert property (p_ident_read)
		else $error("identification read wrong");

	property p_light_eff;
		light_eff > light_integ && light_eff >= light_rep;
	endproperty
	a_light_eff: assert property (p_light_eff)
		else $error("light interval not above integration time");

	property p_freq_default;
		drive_reg[7:5] == 3'h3 |-> em_period == 10'd333;
	endproperty
	a_freq_default: assert property (p_freq_default)
		else $error("60 kHz period wrong");

	property p_current;
		drive_reg[2:0] > 3'h3 ##1 $stable(drive_reg)
			|-> EMIT_CURRENT_MA == 7'h64;
	endproperty
	a_current: assert property (p_current)
		else $error("high current code not 100 mA");

	property p_write_standby;
		wr_pulses && !prox_active |=> pulses_reg == $past(REG_REQ.wdata);
	endproperty
	a_write_standby: assert property (p_write_standby)
		else $error("register write lost in standby");

	property p_prox_spacing;
		PROX_MEAS_START |=> !PROX_MEAS_START [*8];
	endproperty
	a_prox_spacing: assert property (p_prox_spacing)
		else $error("proximity starts too close");

	property p_light_default;
		light_rate_reg[2:0] == 3'h2 |-> light_rep == 21'd500000;
	endproperty
	a_light_default: assert property (p_light_default)
		else $error("light default interval wrong");

endmodule

// ==== test/plmc_host_model.sv ====
// Host side of the register port: byte writes and reads on request.
// Assumes the bench calls write and read from one process only.
`timescale 1ns/1ps

module plmc_host_model
	import plmc_pkg::*;
(
	input  wire logic       sys_clk,
	output plmc_req_t       req,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid
);
	initial req = '0;

	// ======================================================
	// Register cycles, request held for the one edge that takes it
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		req <= '0;
	endtask

	// Answer without its valid strobe reads back as unknown
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		req <= '0;
		@(posedge sys_clk);
		d = (rvalid === 1'b1) ? rdata : 8'hxx;
	endtask
endmodule

// ==== test/plmc_top_test.sv ====
// Self-checking bench for the configuration and timing block.
// Assumes TICK_CYCLES of 1, so interval codes count clocks.
`timescale 1ns/1ps

module plmc_top_test;
	import plmc_pkg::*;
	localparam logic [7:0] IDENT = 8'h3c; // Arbitrary value
	logic      sys_clk = 1'b0;
	logic      rst = 1'b1;
	logic      light_en = 1'b0;
	plmc_req_t req;
	logic [7:0] rdata;
	logic [6:0] cur_ma;
	logic [4:0] res_bits;
	logic      rvalid, p_start, p_done, l_start, emit;
	int        n_mismatch = 0;
	int        n_tests = 0;
	int        n_light = 0;
	int        n_prox = 0;
	logic [7:0] d;
	int        n, w, pulses;
	logic      prev;
	logic [7:0] cur_exp [8] = '{5, 10, 20, 50, 100, 100, 100, 100};
	logic [7:0] res_exp [8] = '{20, 19, 18, 17, 16, 12, 8, 4};
	logic [7:0] rst_addr [6] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86};
	logic [7:0] rst_val [6] = '{8'h0c, 8'h6b, 8'h7f, 8'h03, 8'h82, IDENT};

	always #25 sys_clk = ~sys_clk;

	plmc_host_model i_host (
		.sys_clk (sys_clk),
		.req     (req),
		.rdata   (rdata),
		.rvalid  (rvalid)
	);

	plmc_top #(.TICK_CYCLES(1), .PART_IDENT(IDENT)) i_dut (
		.SYS_CLK          (sys_clk),
		.RST              (rst),
		.REG_REQ          (req),
		.LIGHT_ENABLE     (light_en),
		.REG_RDATA        (rdata),
		.REG_RVALID       (rvalid),
		.PROX_MEAS_START  (p_start),
		.PROX_BURST_DONE  (p_done),
		.LIGHT_MEAS_START (l_start),
		.EMIT_PULSE       (emit),
		.EMIT_CURRENT_MA  (cur_ma),
		.LIGHT_RES_BITS   (res_bits)
	);

	always @(posedge sys_clk)
	begin
		if (l_start === 1'b1)
			n_light++;
		if (p_start === 1'b1)
			n_prox++;
	end

	// ======================================================
	// Comparison and verdict
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (95000) @(posedge sys_clk);
		n_mismatch++;
		report_and_stop;
	end

	// ======================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		check("current", cur_ma, 8'd50);
		check("resolution", res_bits, 8'd16);
		for (int i = 0; i < 6; i++)
		begin
			i_host.read(rst_addr[i], d);
			check("reset value", d, rst_val[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			i_host.write(8'h82, {3'(i), 2'b01, 3'(i)});
			i_host.read(8'h82, d);
			check("drive", d, {3'(i), 2'b01, 3'(i)});
			check("current", cur_ma, cur_exp[i]);
			i_host.write(8'h85, {3'(i), 2'b00, 3'b111});
			i_host.read(8'h85, d);
			check("light rate", d, {3'(i), 2'b00, 3'b111});
			check("resolution", res_bits, res_exp[i]);
		end
		i_host.write(8'h86, 8'h00);
		i_host.read(8'h86, d);
		check("ident", d, IDENT);
		i_host.read(8'h80, d);
		check("unmapped", d, 8'h00);
		check("standby starts", 16'(n_prox), 16'd0);
		// Fastest repeat, two pulses at 100 kHz, light asked for
		light_en <= 1'b1;
		i_host.write(8'h82, 8'heb);
		i_host.write(8'h83, 8'h02);
		i_host.write(8'h84, 8'h00);
		i_host.write(8'h81, 8'h0e);
		n = 0;
		while (p_start !== 1'b1 && n < 13000)
		begin
			@(posedge sys_clk);
			n++;
		end
		check("prox interval", 16'(n >= 12497 && n <= 12502), 16'd1);
		pulses = 0;
		w = 0;
		prev = 1'b0;
		n = 0;
		while (p_done !== 1'b1 && n < 2000)
		begin
			@(posedge sys_clk);
			if (emit === 1'b1 && prev !== 1'b1)
				pulses++;
			if (emit === 1'b1 && pulses == 1)
				w++;
			prev = emit;
			n++;
		end
		check("pulses", 16'(pulses), 16'd2);
		check("high width", 16'(w), 16'd100);
		i_host.write(8'h83, 8'hff);
		n = 0;
		while (p_start !== 1'b1 && n < 13000)
		begin
			@(posedge sys_clk);
			n++;
		end
		pulses = 0;
		prev = 1'b0;
		n = 0;
		while (p_done !== 1'b1 && n < 52000)
		begin
			@(posedge sys_clk);
			if (emit === 1'b1 && prev !== 1'b1)
				pulses++;
			prev = emit;
			n++;
		end
		check("capped pulses", 16'(pulses), 16'd254);
		// Zero count: burst ends at once, emitter stays dark
		i_host.write(8'h83, 8'h00);
		n = 0;
		while (p_start !== 1'b1 && n < 13000)
		begin
			@(posedge sys_clk);
			n++;
		end
		check("zero burst start", p_start, 1'b1);
		check("zero burst done", p_done, 1'b1);
		pulses = 0;
		repeat (300)
		begin
			@(posedge sys_clk);
			if (emit !== 1'b0)
				pulses++;
		end
		check("zero burst pulses", 16'(pulses), 16'd0);
		check("light starts", 16'(n_light), 16'd0);
		check("light timer", 16'(i_dut.light_cnt_reg), 16'd0);
		report_and_stop;
	end
endmodule
